// ---- rtl/asru_pkg.sv ----
package asru_pkg;
  // ****************************************
  // Widths and operation codes
  // ****************************************
  localparam int DATA_W = 32;
  localparam int CNT_W = 5;
  localparam logic [31:0] MAX_SHIFT = 32'h0000001F;
  localparam logic [31:0] SAT_POS = 32'h7FFFFFFF;
  localparam logic [31:0] SAT_NEG = 32'h80000000;
  localparam logic [1:0] OP_SHIFT_RIGHT = 2'h0;
  localparam logic [1:0] OP_SHIFT_RIGHT_SAT = 2'h1;
  localparam logic [1:0] OP_SHIFT_LEFT_SAT = 2'h2;
  // Condition code field values
  localparam logic [4:0] COND_AL = 5'h00;
  localparam logic [4:0] COND_EQ = 5'h01;
  localparam logic [4:0] COND_NE = 5'h02;
  localparam logic [4:0] COND_PL = 5'h03;
  localparam logic [4:0] COND_MI = 5'h04;
  localparam logic [4:0] COND_CS = 5'h05;
  localparam logic [4:0] COND_CC = 5'h06;
  localparam logic [4:0] COND_VS = 5'h07;
  localparam logic [4:0] COND_VC = 5'h08;
  localparam logic [4:0] COND_GT = 5'h09;
  localparam logic [4:0] COND_GE = 5'h0A;
  localparam logic [4:0] COND_LT = 5'h0B;
  localparam logic [4:0] COND_LE = 5'h0C;
  localparam logic [4:0] COND_HI = 5'h0D;
  localparam logic [4:0] COND_LS = 5'h0E;
  localparam logic [4:0] COND_PNZ = 5'h0F;
  // Register map, byte addresses
  localparam logic [7:0] REG_FLAGS = 8'h00;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_MASK = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0C;
  // Flag bit positions
  localparam int FLG_Z = 0;
  localparam int FLG_N = 1;
  localparam int FLG_C = 2;
  localparam int FLG_V = 3;
  localparam int FLG_SAT1 = 4;
  localparam int FLG_SAT2 = 5;
  // Interrupt event bits
  localparam int EVT_SAT = 0;
  localparam int EVT_DONE = 1;
  localparam int EVT_W = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- rtl/asru_shift_core.sv ----
`timescale 1ns/1ps
// ****************************************
// Combinational shift and saturation core
// ****************************************
module asru_shift_core
  import asru_pkg::*;
(
  input wire logic [1:0] op,
  input wire logic [31:0] src1,
  input wire logic [31:0] src2,
  output logic [31:0] result,
  output logic carry,
  output logic saturated
);
  logic signed [31:0] src1_s;
  logic signed [31:0] amt;
  logic [4:0] cnt;
  logic [4:0] mag;
  logic signed [63:0] wide;
  logic [31:0] rr;

  assign src1_s = signed'(src1);
  // Saturating left form is the mirror of the right form
  assign amt = (op == OP_SHIFT_LEFT_SAT) ? -signed'(src2) : signed'(src2);

  // Select shift behaviour per operation
  always_comb begin
    result = 32'h00000000;
    carry = 1'b0;
    saturated = 1'b0;
    cnt = src2[4:0];
    mag = 5'h00;
    wide = 64'sh0;
    rr = 32'h00000000;
    if (op == OP_SHIFT_RIGHT) begin
      rr = 32'(src1_s >>> cnt);
      result = rr;
      carry = (cnt == 5'h00) ? 1'b0 : src1[cnt - 5'h01];
    end else if (amt >= 0) begin
      // Clamp positive amounts
      mag = (amt > signed'(MAX_SHIFT)) ? 5'h1F : amt[4:0];
      result = 32'(src1_s >>> mag);
    end else if (src1 == 32'h00000000) begin
      result = 32'h00000000;
    end else if (amt < -signed'(MAX_SHIFT)) begin
      result = src1_s[31] ? SAT_NEG : SAT_POS;
      saturated = 1'b1;
    end else begin
      mag = 5'(-amt);
      wide = 64'(64'(src1_s) <<< mag);
      // Saturate to the signed 32-bit range
      if (wide > 64'sh000000007FFFFFFF) begin
        result = SAT_POS;
        saturated = 1'b1;
      end else if (wide < -64'sh0000000080000000) begin
        result = SAT_NEG;
        saturated = 1'b1;
      end else begin
        result = wide[31:0];
      end
    end
  end
endmodule // asru_shift_core

// ---- rtl/asru_unit.sv ----
// Behaviour
// - Right shift fills vacated upper bits with the sign of src1.
// - Right shift count is the low five bits of src2.
// - Result written only when the condition code is true.
// - Flags change only when the set-flags option is given.
// - Right shift sets zero and negative from result; overflow kept.
// - Carry is zero for count zero, else bit count-1 of src1.
// - Saturating form shifts right by amounts 0 to 31.
// - Saturating form clamps positive amounts above 31 to 31.
// - Negative amounts to -31 shift left and saturate to 32 bits.
// - Amounts below -31 give max positive or most negative value; zero src1 gives zero.
// - Saturating form sets overflow if saturated, else clears it.
// - Saturation sets both sticky flags; only reset clears them.
`timescale 1ns/1ps
module asru_unit
  import asru_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  // Operation from decode
  input wire logic op_valid,
  input wire logic [1:0] op_sel,
  input wire logic [31:0] src1,
  input wire logic [31:0] src2,
  input wire logic [4:0] condition_code_field,
  input wire logic set_flags,
  input wire logic has_dest,
  input wire logic [5:0] dest_idx,
  // Writeback to register file
  output logic wb_en,
  output logic [5:0] wb_idx,
  output logic [31:0] wb_data,
  // Flag state
  output logic flag_z,
  output logic flag_n,
  output logic flag_c,
  output logic flag_v,
  output logic sticky_saturation_flag_one,
  output logic sticky_saturation_flag_two,
  output logic irq,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ****************************************
  // Datapath
  // ****************************************
  logic [31:0] core_res;
  logic core_c;
  logic core_sat;
  logic cond_ok;
  logic exec;
  logic z_q, n_q, c_q, v_q, sat1_q, sat2_q;
  logic wb_en_q;
  logic [5:0] wb_idx_q;
  logic [31:0] wb_data_q;
  logic [31:0] last_q;
  logic [EVT_W-1:0] irq_stat_q;
  logic [EVT_W-1:0] irq_mask_q;
  logic [EVT_W-1:0] evt;
  logic [EVT_W-1:0] w1c;
  logic aw_got_q, w_got_q;
  logic [7:0] aw_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic do_wr;

  asru_shift_core u_core (
    .op(op_sel),
    .src1(src1),
    .src2(src2),
    .result(core_res),
    .carry(core_c),
    .saturated(core_sat)
  );

  // Condition test against current flags
  always_comb begin
    unique case (condition_code_field)
      COND_AL: cond_ok = 1'b1;
      COND_EQ: cond_ok = z_q;
      COND_NE: cond_ok = !z_q;
      COND_PL: cond_ok = !n_q;
      COND_MI: cond_ok = n_q;
      COND_CS: cond_ok = c_q;
      COND_CC: cond_ok = !c_q;
      COND_VS: cond_ok = v_q;
      COND_VC: cond_ok = !v_q;
      COND_GT: cond_ok = (n_q == v_q) && !z_q;
      COND_GE: cond_ok = (n_q == v_q);
      COND_LT: cond_ok = (n_q != v_q);
      COND_LE: cond_ok = z_q || (n_q != v_q);
      COND_HI: cond_ok = !c_q && !z_q;
      COND_LS: cond_ok = c_q || z_q;
      COND_PNZ: cond_ok = !n_q && !z_q;
      default: cond_ok = 1'b0;
    endcase
  end

  assign exec = op_valid && cond_ok;

  // Result writeback
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_en_q <= 1'b0;
      wb_idx_q <= 6'h00;
      wb_data_q <= 32'h00000000;
    end else begin
      wb_en_q <= exec && has_dest;
      if (exec) begin
        wb_idx_q <= dest_idx;
        wb_data_q <= core_res;
      end
    end
  end

  // Zero and negative follow the result of every form
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      z_q <= 1'b0;
      n_q <= 1'b0;
    end else if (exec && set_flags) begin
      z_q <= (core_res == 32'h00000000);
      n_q <= core_res[31];
    end
  end

  // Carry, touched by the plain right shift only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      c_q <= 1'b0;
    end else if (exec && set_flags && op_sel == OP_SHIFT_RIGHT) begin
      c_q <= core_c;
    end
  end

  // Overflow, touched by the saturating forms only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      v_q <= 1'b0;
    end else if (exec && set_flags && op_sel != OP_SHIFT_RIGHT) begin
      v_q <= core_sat;
    end
  end

  // Sticky saturation flags
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sat1_q <= 1'b0;
      sat2_q <= 1'b0;
    end else if (exec && set_flags && core_sat) begin
      sat1_q <= 1'b1;
      sat2_q <= 1'b1;
    end
  end

  // Last result seen, readable even without destination
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_q <= 32'h00000000;
    end else if (exec) begin
      last_q <= core_res;
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  assign evt[EVT_SAT] = exec && core_sat;
  assign evt[EVT_DONE] = exec;
  assign do_wr = aw_got_q && w_got_q && !bvalid_q;
  assign w1c = (do_wr && aw_q == REG_IRQ_STATUS && ws_q[0]) ?
    wd_q[EVT_W-1:0] : '0;

  // Sticky status, set wins over clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~w1c) | evt;
    end
  end

  // Mask register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_q <= '0;
    end else if (do_wr && aw_q == REG_IRQ_MASK && ws_q[0]) begin
      irq_mask_q <= wd_q[EVT_W-1:0];
    end
  end

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  assign s_axi_awready = !aw_got_q;
  assign s_axi_wready = !w_got_q;

  // Capture address and data in either order
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_q <= 8'h00;
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_got_q) begin
        aw_got_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_got_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_got_q) begin
        w_got_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end else if (do_wr) begin
        w_got_q <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q <= (aw_q == REG_IRQ_STATUS || aw_q == REG_IRQ_MASK) ?
        RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  assign s_axi_arready = !rvalid_q;

  // Read data captured from the addressed register, held until taken
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      unique case (s_axi_araddr)
        REG_FLAGS: rdata_q <= {26'h0, sat2_q, sat1_q, v_q, c_q, n_q, z_q};
        REG_IRQ_STATUS: rdata_q <= {30'h0, irq_stat_q};
        REG_IRQ_MASK: rdata_q <= {30'h0, irq_mask_q};
        REG_RESULT: rdata_q <= last_q;
        default: begin
          rdata_q <= 32'h00000000;
          rresp_q <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Outputs
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign wb_en = wb_en_q;
  assign wb_idx = wb_idx_q;
  assign wb_data = wb_data_q;
  assign flag_z = z_q;
  assign flag_n = n_q;
  assign flag_c = c_q;
  assign flag_v = v_q;
  assign sticky_saturation_flag_one = sat1_q;
  assign sticky_saturation_flag_two = sat2_q;
  assign irq = |(irq_stat_q & irq_mask_q);
endmodule // asru_unit

// ---- sim/asru_unit_properties.sv ----
`timescale 1ns/1ps
// **********
// Checker on the unit ports
// **********
module asru_props
  import asru_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic op_valid,
  input wire logic [1:0] op_sel,
  input wire logic [31:0] src1,
  input wire logic [31:0] src2,
  input wire logic [4:0] condition_code_field,
  input wire logic set_flags,
  input wire logic has_dest,
  input wire logic wb_en,
  input wire logic [31:0] wb_data,
  input wire logic flag_z,
  input wire logic flag_n,
  input wire logic flag_c,
  input wire logic flag_v,
  input wire logic sticky_saturation_flag_one,
  input wire logic sticky_saturation_flag_two
);
  logic [31:0] shr_exp;
  logic c_exp;
  // Expected right shift and last bit shifted out
  always_comb begin
    shr_exp = $signed(src1) >>> src2[4:0];
    c_exp = (src2[4:0] == 5'h00) ? 1'b0 : src1[src2[4:0] - 5'h01];
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_shr;
    op_valid && op_sel == OP_SHIFT_RIGHT && condition_code_field == COND_AL;
  endsequence
  a_shr_data:
    assert property (s_shr ##0 has_dest |=> wb_en && wb_data == $past(shr_exp))
    else $error("shift result wrong");
  a_shr_carry:
    assert property (s_shr ##0 set_flags |=> flag_c == $past(c_exp))
    else $error("shift carry wrong");
  a_shr_keep_v:
    assert property (op_valid && op_sel == OP_SHIFT_RIGHT |=> $stable(flag_v))
    else $error("overflow changed by shift");
  a_sat_keep_c:
    assert property (op_valid && op_sel != OP_SHIFT_RIGHT |=> $stable(flag_c))
    else $error("carry changed by saturating op");
  a_no_set_flags:
    assert property (op_valid && !set_flags |=> $stable({flag_z, flag_n,
      flag_c, flag_v, sticky_saturation_flag_one}))
    else $error("flags changed without request");
  a_cc_false:
    assert property (op_valid && condition_code_field[4] |=> !wb_en &&
      $stable({flag_z, flag_n, flag_c, flag_v}))
    else $error("false condition executed");
  a_wb_cause:
    assert property (wb_en |-> $past(op_valid) && $past(has_dest))
    else $error("writeback without destination");
  a_sticky_keep:
    assert property (sticky_saturation_flag_one |=> sticky_saturation_flag_one
      && sticky_saturation_flag_two)
    else $error("sticky flag dropped");
  a_zn_track:
    assert property (op_valid && condition_code_field == COND_AL &&
      set_flags && has_dest |=> flag_z == (wb_data == 32'h00000000) &&
      flag_n == wb_data[31])
    else $error("zero or negative wrong");
endmodule // asru_props
bind asru_unit asru_props u_props (
  .ref_clk, .rst_n, .op_valid, .op_sel, .src1, .src2,
  .condition_code_field, .set_flags, .has_dest, .wb_en, .wb_data,
  .flag_z, .flag_n, .flag_c, .flag_v, .sticky_saturation_flag_one,
  .sticky_saturation_flag_two
);

// ---- sim/asru_regfile_model.sv ----
`timescale 1ns/1ps
// **********
// Register file behind writeback
// **********
module asru_regfile_model (
  input wire logic ref_clk,
  input wire logic wb_en,
  input wire logic [5:0] wb_idx,
  input wire logic [31:0] wb_data
);
  logic [31:0] regs [64];
  int n_wr = 0;
  // One word captured per writeback pulse
  always @(posedge ref_clk) begin
    if (wb_en) begin
      regs[wb_idx] <= wb_data;
      n_wr <= n_wr + 1;
    end
  end
endmodule // asru_regfile_model

// ---- sim/tb_arith_shift_right_unit.sv ----
`timescale 1ns/1ps
// **********
// Bench for the shift unit
// **********
`define CHK(A, E) begin checks++; if ((A) !== (E)) begin n_fail++; \
  $display("BAD %0t got %h want %h", $time, A, E); end end
module tb_arith_shift_right_unit
  import asru_pkg::*;
;
  logic ref_clk, rst_n, op_valid, set_flags, has_dest, wb_en, irq;
  logic flag_z, flag_n, flag_c, flag_v;
  logic sticky_saturation_flag_one, sticky_saturation_flag_two;
  logic [1:0] op_sel, s_axi_bresp, s_axi_rresp;
  logic [4:0] condition_code_field;
  logic [5:0] dest_idx, wb_idx, flg, xf;
  logic [31:0] src1, src2, wb_data, s_axi_wdata, s_axi_rdata;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic ez, en, ec, ev, es;
  int n_fail = 0;
  int checks = 0;
  int nw = 0;
  assign flg = {sticky_saturation_flag_two, sticky_saturation_flag_one,
    flag_v, flag_c, flag_n, flag_z};
  asru_unit dut (
    .ref_clk, .rst_n, .op_valid, .op_sel, .src1, .src2,
    .condition_code_field, .set_flags, .has_dest, .dest_idx, .wb_en,
    .wb_idx, .wb_data, .flag_z, .flag_n, .flag_c, .flag_v,
    .sticky_saturation_flag_one, .sticky_saturation_flag_two, .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready
  );
  asru_regfile_model mdl (.ref_clk, .wb_en, .wb_idx, .wb_data);
  // Clock at 40 MHz
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Saturating reference, positive amounts shift right
  function automatic logic [31:0] sat_ref(input logic [31:0] a, s,
                                          output logic v);
    longint p;
    int n;
    v = 1'b0;
    if (!s[31]) return $signed(a) >>> ((s > MAX_SHIFT) ? 5'h1F : s[4:0]);
    n = ($signed(s) < -32) ? 32 : -$signed(s);
    p = longint'($signed(a)) <<< n;
    v = (p != longint'($signed(p[31:0])));
    return v ? (a[31] ? SAT_NEG : SAT_POS) : p[31:0];
  endfunction
  // Drive one operation, predict and compare its outcome
  task automatic do_op(input logic [1:0] op, input logic [31:0] a, b,
                       input logic [4:0] cnd, input logic sf, hd, ex);
    logic c, v;
    logic [31:0] r;
    c = 1'b0;
    v = 1'b0;
    if (op == OP_SHIFT_RIGHT) begin
      r = $signed(a) >>> b[4:0];
      if (b[4:0] != 5'h00) c = a[b[4:0] - 5'h01];
    end else begin
      r = sat_ref(a, (op == OP_SHIFT_LEFT_SAT) ? -b : b, v);
    end
    @(posedge ref_clk);
    {op_valid, op_sel, src1, src2, condition_code_field, set_flags, has_dest,
      dest_idx} <= {1'b1, op, a, b, cnd, sf, hd, dest_idx + 6'h01};
    @(posedge ref_clk);
    op_valid <= 1'b0;
    if (ex && hd) nw++;
    if (ex && sf) begin
      ez = (r == 32'h00000000);
      en = r[31];
      if (op == OP_SHIFT_RIGHT) ec = c;
      else begin
        ev = v;
        es = es | v;
      end
    end
    xf = {es, es, ev, ec, en, ez};
    #1;
    `CHK(wb_en, ex && hd)
    if (ex && hd) `CHK(wb_data, r)
    `CHK(flg, xf)
    @(posedge ref_clk);
    #1;
    `CHK(mdl.n_wr, nw)
    if (ex && hd) `CHK(mdl.regs[dest_idx], r)
  endtask
  // Bus write, response code returned
  task automatic axw(input logic [7:0] ad, input logic [31:0] d,
                     output logic [1:0] r);
    @(posedge ref_clk);
    {s_axi_awaddr, s_axi_awvalid} <= {ad, 1'b1};
    {s_axi_wdata, s_axi_wvalid} <= {d, 1'b1};
    s_axi_wstrb <= 4'hF;
    s_axi_bready <= 1'b1;
    // Wait for the response has no timeout of its own; the watchdog ends a hung wait
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask
  // Bus read, data and response returned
  task automatic axr(input logic [7:0] ad, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge ref_clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {ad, 2'b11};
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // Right shift over signs, zero count and masked high bits
  task automatic t_shr;
    logic [31:0] a[5] = '{32'h80001111, 32'hF0000021, 32'h12345678,
      32'h80000000, 32'h7FFFFFFF};
    logic [31:0] b[5] = '{32'h00000004, 32'hFFFFFF25, 32'h00000000,
      32'h0000001F, 32'h00000001};
    for (int i = 0; i < 5; i++)
      do_op(OP_SHIFT_RIGHT, a[i], b[i], COND_AL, 1'b1, 1'b1, 1'b1);
  endtask
  // Condition codes gate execution, flags kept without request
  task automatic t_cond;
    logic [4:0] cnd[5] = '{COND_EQ, COND_NE, COND_CS, COND_CC, 5'h10};
    do_op(OP_SHIFT_RIGHT, 32'h00000001, 32'h00000001, COND_AL, 1'b1, 1'b1,
      1'b1);
    for (int i = 0; i < 5; i++) do_op(OP_SHIFT_RIGHT_SAT, 32'h40000000,
      32'hFFFFFFFE, cnd[i], 1'b0, 1'b1, i == 0 || i == 2);
  endtask
  // Saturating shifts both ways, clamps and zero input
  task automatic t_sat;
    logic [1:0] o[10] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1,
      2'h2, 2'h2};
    logic [31:0] a[10] = '{32'h00001111, 32'h7FFFFFFF, 32'h80000000,
      32'h10001111, 32'h00001111, 32'hFFFFFF00, 32'h00000001, 32'h00000000,
      32'h10001111, 32'h00001111};
    logic [31:0] b[10] = '{32'h00000001, 32'h00000021, 32'h00000021,
      32'hFFFFFFFD, 32'hFFFFFFFF, 32'hFFFFFFE1, 32'hFFFFFFD8, 32'hFFFFFFD8,
      32'h00000003, 32'hFFFFFFFF};
    for (int i = 0; i < 10; i++)
      do_op(o[i], a[i], b[i], COND_AL, 1'b1, 1'b1, 1'b1);
  endtask
  // Registers, interrupt raise, clear and mask, bus errors
  task automatic t_bus;
    logic [31:0] d;
    logic [1:0] r;
    axr(REG_IRQ_MASK, d, r);
    `CHK(d, 32'h00000000)
    axw(REG_IRQ_MASK, 32'h00000001, r);
    axw(REG_IRQ_STATUS, 32'h00000003, r);
    #1;
    `CHK(irq, 1'b0)
    do_op(OP_SHIFT_RIGHT_SAT, 32'h40000000, 32'hFFFFFFFE, COND_AL, 1'b1,
      1'b0, 1'b1);
    `CHK(irq, 1'b1)
    axr(REG_RESULT, d, r);
    `CHK(d, SAT_POS)
    axr(REG_FLAGS, d, r);
    `CHK(d[5:0], xf)
    axw(REG_IRQ_STATUS, 32'h00000001, r);
    #1;
    `CHK(irq, 1'b0)
    axw(REG_IRQ_MASK, 32'h00000000, r);
    do_op(OP_SHIFT_RIGHT_SAT, 32'h40000000, 32'hFFFFFFFE, COND_AL, 1'b1,
      1'b0, 1'b1);
    `CHK(irq, 1'b0)
    axw(REG_FLAGS, 32'h00000000, r);
    `CHK(r, RESP_SLVERR)
    axr(8'h10, d, r);
    `CHK(r, RESP_SLVERR)
  endtask
  // Verdict and end of run
  task automatic final_report;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0;
    {op_valid, set_flags, has_dest, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_wstrb} = '0;
    {op_sel, src1, src2, condition_code_field, dest_idx} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ez, en, ec, ev, es} = '0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_shr();
    t_cond();
    t_sat();
    t_bus();
    final_report();
  end
  // Watchdog against a hang
  initial begin
    #400000;
    n_fail++;
    final_report();
  end
endmodule // tb_arith_shift_right_unit
